// ===== irq_vectoring_unit.sv
// irq_vectoring_unit.sv: interrupt flags, enables, vector redirection and context shadowing
// assumes: apb master on clk; core presents context, q1 strobe, sleep and return requests
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module irq_vectoring_unit
    import irq_vector_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [7:0]                    periph_events,
    input  wire logic                          ext_pin,
    input  wire logic                          q1_strobe,
    input  wire logic                          sleep_req,
    input  wire logic                          instr_done,
    input  wire logic                          return_from_interrupt,
    input  wire irq_vector_pkg::core_context_s live_ctx,
    output irq_vector_pkg::core_redirect_s     redirect,
    output irq_vector_pkg::core_context_s      restore_ctx,
    output logic                               sleeping
);
`include "irq_vector_map.svh"

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                 global_irq_enable;
    logic                 peripheral_group_irq_enable;
    logic                 ext_pin_edge_select;
    logic                 ext_pin_irq_enable;
    logic                 ext_pin_irq_flag;
    logic [7:0]           source_irq_enables;
    logic [7:0]           flag_register_one;
    logic                 pin_edge;
    logic                 wake_pending;
    logic                 take_irq;
    logic                 sw_wr;
    logic                 sw_rd;
    logic                 shadow_wr;
    logic [2:0]           shadow_sel;
    logic                 addr_ok;
    logic                 ctl_wr;
    logic                 ena_wr;
    logic                 clr_wr;
    logic                 entry_now;
    logic                 setup_cyc;
    logic                 setup_rd;
    logic                 periph_pending;
    logic                 pin_pending;
    // reset image of the control register
    localparam logic [7:0] CONTROL_INIT = `CONTROL_RESET;
    seq_state_e           state;
    core_context_s        shadow;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
        is_addr = (a == ofs);
    endfunction : is_addr

    // word-aligned shadow window
    function automatic logic is_shadow(input logic [11:0] a);
        is_shadow = (a >= `OFS_SHADOW_ACC) && (a <= `OFS_SHADOW_PCLATCH)
                    && (a[1:0] == 2'b00);
    endfunction : is_shadow

    // mapped register offsets
    function automatic logic reg_known(input logic [11:0] a);
        if (a == `OFS_CONTROL) begin
            reg_known = 1'b1;
        end else if (a == `OFS_FLAGS) begin
            reg_known = 1'b1;
        end else if (a == `OFS_ENABLES) begin
            reg_known = 1'b1;
        end else if (a == `OFS_STATUS) begin
            reg_known = 1'b1;
        end else if (a == `OFS_FLAG_CLEAR) begin
            reg_known = 1'b1;
        end else begin
            reg_known = is_shadow(a);
        end
    endfunction : reg_known

    // ------------------------------------------------------------
    // pending logic
    // ------------------------------------------------------------
    // gated request before the global enable
    assign periph_pending = |(flag_register_one & source_irq_enables)
                            & peripheral_group_irq_enable;
    assign pin_pending    = ext_pin_irq_flag & ext_pin_irq_enable;
    assign wake_pending   = periph_pending | pin_pending;
    assign take_irq       = global_irq_enable & wake_pending & q1_strobe;
    // a return in the same cycle wins over entry
    assign entry_now      = take_irq & (state == ST_RUN) & ~return_from_interrupt;

    assign sw_wr      = psel & penable & pwrite;
    assign sw_rd      = psel & penable & ~pwrite;
    assign setup_cyc  = psel & ~penable;
    assign setup_rd   = setup_cyc & ~pwrite;
    assign ctl_wr     = sw_wr & is_addr(paddr, `OFS_CONTROL);
    assign ena_wr     = sw_wr & is_addr(paddr, `OFS_ENABLES);
    assign clr_wr     = sw_wr & is_addr(paddr, `OFS_FLAG_CLEAR);
    assign addr_ok    = reg_known(paddr);
    assign shadow_sel = 3'((paddr - `OFS_SHADOW_ACC) >> 2);
    assign shadow_wr  = sw_wr & is_shadow(paddr);

    // ------------------------------------------------------------
    // edge detect and shadows
    // ------------------------------------------------------------
    pin_edge_sync u_pin (
        .clk         (clk),
        .srst        (srst),
        .pin         (ext_pin),
        .edge_select (ext_pin_edge_select),
        .edge_seen   (pin_edge)
    );

    context_shadow u_shadow (
        .clk      (clk),
        .srst     (srst),
        .save     (entry_now),
        .live_ctx (live_ctx),
        .wr_sel   (shadow_sel),
        .wr_en    (shadow_wr && !entry_now),
        .wr_data  (pwdata[15:0]),
        .shadow   (shadow)
    );

    // ------------------------------------------------------------
    // enables
    // ------------------------------------------------------------
    // group enable
    always_ff @(posedge clk) begin
        if (srst) begin
            peripheral_group_irq_enable <= 1'b0;
        end else if (ctl_wr) begin
            peripheral_group_irq_enable <= pwdata[`CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT];
        end
    end

    // edge select, rising after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_pin_edge_select <= CONTROL_INIT[`CTL_EDGE_BIT];
        end else if (ctl_wr) begin
            ext_pin_edge_select <= pwdata[`CTL_EDGE_BIT];
        end
    end

    // per-source enables
    always_ff @(posedge clk) begin
        if (srst) begin
            source_irq_enables <= 8'h00;
        end else if (ena_wr) begin
            source_irq_enables <= pwdata[7:0];
        end
    end

    // pin enable
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_pin_irq_enable <= 1'b0;
        end else if (ena_wr) begin
            ext_pin_irq_enable <= pwdata[8];
        end
    end

    // global enable: cleared on entry, set on return, else software
    always_ff @(posedge clk) begin
        if (srst) begin
            global_irq_enable <= 1'b0;
        end else if (entry_now) begin
            global_irq_enable <= 1'b0;
        end else if (return_from_interrupt) begin
            global_irq_enable <= 1'b1;
        end else if (ctl_wr) begin
            global_irq_enable <= pwdata[`CTL_GIE_BIT];
        end
    end

    // ------------------------------------------------------------
    // flags: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_register_one <= 8'h00;
        end else if (clr_wr) begin
            flag_register_one <= (flag_register_one & ~pwdata[7:0]) | periph_events;
        end else begin
            flag_register_one <= flag_register_one | periph_events;
        end
    end

    // pin flag
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_pin_irq_flag <= 1'b0;
        end else if (clr_wr) begin
            ext_pin_irq_flag <= (ext_pin_irq_flag & ~pwdata[8]) | pin_edge;
        end else begin
            ext_pin_irq_flag <= ext_pin_irq_flag | pin_edge;
        end
    end

    // ------------------------------------------------------------
    // sequencer: run, entry, sleep, wake
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= ST_RUN;
            redirect <= '0;
        end else begin
            redirect <= '0;
            case (state)
                ST_RUN: begin
                    if (return_from_interrupt) begin
                        redirect.pop_pc  <= 1'b1;
                        redirect.restore <= 1'b1;
                    end else if (take_irq) begin
                        redirect.flush       <= 1'b1;
                        redirect.push_pc     <= 1'b1;
                        redirect.vector_req  <= 1'b1;
                        redirect.vector_addr <= `IRQ_VECTOR;
                        state                <= ST_ENTRY;
                    end else if (sleep_req) begin
                        state    <= ST_SLEEP;
                    end
                end
                ST_ENTRY: begin
                    state <= ST_RUN;
                end
                ST_SLEEP: begin
                    if (wake_pending) begin
                        state    <= ST_WAKE_ONE;
                    end
                end
                ST_WAKE_ONE: begin
                    if (instr_done) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // sleep level towards the core
    always_ff @(posedge clk) begin
        if (srst) begin
            sleeping <= 1'b0;
        end else if (state == ST_RUN) begin
            sleeping <= sleep_req & ~return_from_interrupt & ~take_irq;
        end else if (state == ST_SLEEP && wake_pending) begin
            sleeping <= 1'b0;
        end
    end

    // context driven back to the core on return
    always_ff @(posedge clk) begin
        if (srst) begin
            restore_ctx <= '0;
        end else if (return_from_interrupt && state == ST_RUN) begin
            restore_ctx <= shadow;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_cyc;
        end
    end

    // unmapped offsets answer with an error
    always_ff @(posedge clk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_cyc & ~addr_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= 32'h0000_0000;
            if (is_addr(paddr, `OFS_CONTROL)) begin
                prdata[`CTL_GIE_BIT]  <= global_irq_enable;
                prdata[`CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT] <= peripheral_group_irq_enable;
                prdata[`CTL_EDGE_BIT] <= ext_pin_edge_select;
            end else if (is_addr(paddr, `OFS_FLAGS)) begin
                prdata[8:0] <= {ext_pin_irq_flag, flag_register_one};
            end else if (is_addr(paddr, `OFS_ENABLES)) begin
                prdata[8:0] <= {ext_pin_irq_enable, source_irq_enables};
            end else if (is_addr(paddr, `OFS_STATUS)) begin
                prdata[3:0] <= state;
                prdata[4]   <= wake_pending;
            end else if (is_addr(paddr, `OFS_SHADOW_ACC)) begin
                prdata[7:0] <= shadow.acc;
            end else if (is_addr(paddr, `OFS_SHADOW_STATUS)) begin
                prdata[7:0] <= shadow.status;
            end else if (is_addr(paddr, `OFS_SHADOW_BANK)) begin
                prdata[5:0] <= shadow.bank;
            end else if (is_addr(paddr, `OFS_SHADOW_PTR)) begin
                prdata[15:0] <= shadow.ptr;
            end else if (is_addr(paddr, `OFS_SHADOW_PCLATCH)) begin
                prdata[6:0] <= shadow.pclatch;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = sw_rd;
endmodule : irq_vectoring_unit
`default_nettype wire

// ===== irq_vector_map.svh
// irq_vector_map.svh: offsets, field positions, reset values and timing for the interrupt unit
// assumes: included by irq_vectoring_unit and context_shadow (not the package) by its bare name
`ifndef IRQ_VECTOR_MAP_SVH
`define IRQ_VECTOR_MAP_SVH

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define OFS_CONTROL        12'h000
`define OFS_FLAGS          12'h004
`define OFS_ENABLES        12'h008
`define OFS_STATUS         12'h00C
`define OFS_SHADOW_ACC     12'h010
`define OFS_SHADOW_STATUS  12'h014
`define OFS_SHADOW_BANK    12'h018
`define OFS_SHADOW_PTR     12'h01C
`define OFS_SHADOW_PCLATCH 12'h020
`define OFS_FLAG_CLEAR     12'h024
`define SHADOW_BANK_NUM    5'd31

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTL_GIE_BIT        7
`define CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT       6
`define CTL_EDGE_BIT       0
`define NUM_PERIPH         8

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define CONTROL_RESET      8'h01
`define IRQ_VECTOR         16'h0004
`define STATUS_SAVE_MASK   8'hE7
`define QUARTER_PHASES     2'd3

`endif

// ===== irq_vector_pkg.sv
// irq_vector_pkg.sv: types shared by the interrupt vectoring unit
// assumes: the map header is on the include path
package irq_vector_pkg;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  status;
        logic [5:0]  bank;
        logic [15:0] ptr;
        logic [6:0]  pclatch;
    } core_context_s;

    typedef struct packed {
        logic        vector_req;
        logic [15:0] vector_addr;
        logic        flush;
        logic        push_pc;
        logic        pop_pc;
        logic        restore;
    } core_redirect_s;

    typedef enum logic [3:0] {
        ST_RUN      = 4'b0001,
        ST_ENTRY    = 4'b0010,
        ST_SLEEP    = 4'b0100,
        ST_WAKE_ONE = 4'b1000
    } seq_state_e;

endpackage : irq_vector_pkg

// ===== pin_edge_sync.sv
// pin_edge_sync.sv: synchronises the external interrupt pin and detects the selected edge
// assumes: pin is asynchronous to clk; edge_select comes from clk-domain logic
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    input  wire logic edge_select,
    output logic      edge_seen
);
    logic [2:0] sync;
    logic       stable;

    // three flops; a change counts once second and third agree
    always_ff @(posedge clk) begin
        if (srst) begin
            sync   <= 3'b000;
            stable <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            sync <= {sync[1:0], pin};
            edge_seen <= 1'b0;
            if (sync[1] == sync[2] && sync[2] != stable) begin
                stable    <= sync[2];
                edge_seen <= (sync[2] == edge_select);
            end
        end
    end
endmodule : pin_edge_sync
`default_nettype wire

// ===== context_shadow.sv
// context_shadow.sv: shadow copies of the core context, saved on entry, restored on exit
// assumes: save and software write never collide with restore in one cycle
`timescale 1ns/100ps
`default_nettype none
module context_shadow
    import irq_vector_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          save,
    input  wire irq_vector_pkg::core_context_s live_ctx,
    input  wire logic [2:0]                    wr_sel,
    input  wire logic                          wr_en,
    input  wire logic [15:0]                   wr_data,
    output irq_vector_pkg::core_context_s      shadow
);
`include "irq_vector_map.svh"

    always_ff @(posedge clk) begin
        if (srst) begin
            shadow <= '0;
        end else if (save) begin
            shadow        <= live_ctx;
            shadow.status <= live_ctx.status & `STATUS_SAVE_MASK;
        end else if (wr_en) begin
            case (wr_sel)
                3'd0: shadow.acc     <= wr_data[7:0];
                3'd1: shadow.status  <= wr_data[7:0] & `STATUS_SAVE_MASK;
                3'd2: shadow.bank    <= wr_data[5:0];
                3'd3: shadow.ptr     <= wr_data;
                default: shadow.pclatch <= wr_data[6:0];
            endcase
        end
    end
endmodule : context_shadow
`default_nettype wire

// ===== irq_unit_props.sv
// irq_unit_props.sv: port checker for the interrupt vectoring unit
// assumes: bound to every irq_vectoring_unit, single clock domain
`timescale 1ns/100ps
`default_nettype none
module irq_unit_props
    import irq_vector_pkg::*;
(
    input wire logic                           clk,
    input wire logic                           srst,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           q1_strobe,
    input wire logic                           return_from_interrupt,
    input wire logic                           sleeping,
    input wire irq_vector_pkg::core_redirect_s redirect
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_vec_entry: assert property (redirect.vector_req |->
        redirect.vector_addr == 16'h0004 && redirect.flush && redirect.push_pc)
        else $error("vector entry bundle wrong");
    a_vec_single: assert property (redirect.vector_req |=> !redirect.vector_req)
        else $error("vector request longer than one cycle");
    a_q1_sample: assert property (redirect.vector_req |-> $past(q1_strobe))
        else $error("vector not taken at first quarter");
    a_reset_quiet: assert property ($fell(srst) |-> !redirect.vector_req && !sleeping)
        else $error("activity right after reset");
    a_return_pop: assert property (return_from_interrupt |->
        ##[1:2] (redirect.pop_pc && redirect.restore))
        else $error("return gave no pop and restore");
    a_no_vec_asleep: assert property (sleeping |-> !redirect.vector_req)
        else $error("vector while asleep");
    a_wake_first: assert property ($fell(sleeping) |-> !redirect.vector_req [*2])
        else $error("vector too soon after wake");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");

    c_vec: cover property (redirect.vector_req);
    c_wake: cover property ($fell(sleeping));
    c_ret: cover property (redirect.restore);
endmodule : irq_unit_props

bind irq_vectoring_unit irq_unit_props chk_u (.clk, .srst, .psel, .penable, .pready,
    .pslverr, .q1_strobe, .return_from_interrupt, .sleeping, .redirect);
`default_nettype wire

// ===== core_model.sv
// core_model.sv: processor core stand-in, four clocks per instruction
// assumes: clk and srst of the bench; flush restarts the instruction
`timescale 1ns/100ps
`default_nettype none
module core_model
    import irq_vector_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           srst,
    input  wire irq_vector_pkg::core_redirect_s redirect,
    output logic                                q1_strobe,
    output logic                                instr_done,
    output irq_vector_pkg::core_context_s       live_ctx
);
    logic [1:0] phase;
    always_ff @(posedge clk) begin
        if (srst || redirect.flush) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    // first quarter opens each instruction
    assign q1_strobe = !srst && phase == 2'h0;
    // instruction after sleep completes before any vector
    assign instr_done = !srst && phase == 2'h3;
    // context moves on with every instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            live_ctx <= 45'h0a5_f33c_c3a5;
        end else if (instr_done) begin
            live_ctx <= {live_ctx[43:0], ~live_ctx[44]};
        end
    end
endmodule : core_model
`default_nettype wire

// ===== interrupt_vectoring_unit_bench.sv
// interrupt_vectoring_unit_bench.sv: self-checking bench for the interrupt unit
// assumes: core_model drives quarter strobe, instruction done and context
`timescale 1ns/100ps
`default_nettype none
module interrupt_vectoring_unit_bench;
    import irq_vector_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic        err;
    } row_s;
    // reads compare d, writes send d
    localparam row_s rows [8] = '{
        '{1'b0, 12'h000, 32'h0000_0001, 1'b0}, '{1'b0, 12'h008, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h004, 32'h0000_0000, 1'b0}, '{1'b1, 12'h010, 32'h0000_00a5, 1'b0},
        '{1'b0, 12'h010, 32'h0000_00a5, 1'b0}, '{1'b1, 12'h01c, 32'h0000_beef, 1'b0},
        '{1'b0, 12'h01c, 32'h0000_beef, 1'b0}, '{1'b0, 12'h0fc, 32'h0000_0000, 1'b1}};
    logic clk, srst, psel, penable, pwrite, pready, pslverr, ext_pin, q1_strobe;
    logic sleep_req, instr_done, return_from_interrupt, sleeping, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] periph_events;
    core_context_s live_ctx, restore_ctx, ctx;
    core_redirect_s redirect;
    int error_cnt = 0;
    int n_checks = 0;

    irq_vectoring_unit dut_u (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .periph_events, .ext_pin, .q1_strobe, .sleep_req,
        .instr_done, .return_from_interrupt, .live_ctx, .redirect, .restore_ctx, .sleeping);
    core_model core_u (.clk, .srst, .redirect, .q1_strobe, .instr_done, .live_ctx);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, x);
    endtask : rdc
    task automatic fire(input logic [7:0] ev, input logic sl, input logic rt);
        periph_events <= ev;
        sleep_req <= sl;
        return_from_interrupt <= rt;
        @(posedge clk);
        periph_events <= 8'h00;
        sleep_req <= 1'b0;
        return_from_interrupt <= 1'b0;
        @(posedge clk);
    endtask : fire
    task automatic wait_vec(input logic x);
        logic hit;
        hit = 1'b0;
        repeat (40) begin
            @(posedge clk);
            if (redirect.vector_req === 1'b1 && !hit) begin
                hit = 1'b1;
                ctx = live_ctx;
            end
        end
        chk({31'h0000_0000, hit}, {31'h0000_0000, x});
    endtask : wait_vec

    initial begin
        int wt;
        {srst, psel, penable, pwrite, ext_pin, sleep_req, return_from_interrupt} = 7'h01 << 6;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        periph_events = 8'h00;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d);
            chk({31'h0000_0000, er}, {31'h0000_0000, rows[i].err});
        end
        wr(12'h008, 32'h0000_0004);
        wr(12'h000, 32'h0000_0081);
        fire(8'h04, 1'b0, 1'b0);
        wait_vec(1'b0);
        rdc(12'h004, 32'h0000_0004);
        wr(12'h000, 32'h0000_00c1);
        wait_vec(1'b1);
        rdc(12'h000, 32'h0000_0041);
        rdc(12'h014, {24'h00_0000, ctx.status & 8'he7});
        rdc(12'h010, {24'h00_0000, ctx.acc});
        wr(12'h024, 32'h0000_0004);
        wr(12'h010, 32'h0000_003c);
        fire(8'h00, 1'b0, 1'b1);
        chk({24'h00_0000, restore_ctx.acc}, 32'h0000_003c);
        rdc(12'h000, 32'h0000_00c1);
        ext_pin <= 1'b1;
        wait_vec(1'b0);
        rdc(12'h004, 32'h0000_0100);
        wr(12'h024, 32'h0000_0100);
        ext_pin <= 1'b0;
        repeat (10) @(posedge clk);
        rdc(12'h004, 32'h0000_0000);
        wr(12'h000, 32'h0000_00c0);
        wr(12'h008, 32'h0000_0100);
        ext_pin <= 1'b1;
        repeat (10) @(posedge clk);
        rdc(12'h004, 32'h0000_0000);
        ext_pin <= 1'b0;
        wait_vec(1'b1);
        rdc(12'h004, 32'h0000_0100);
        wr(12'h024, 32'h0000_0100);
        wr(12'h008, 32'h0000_0004);
        for (int g = 0; g < 2; g++) begin
            wr(12'h000, {24'h00_0000, g[0], 7'h40});
            fire(8'h00, 1'b1, 1'b0);
            chk({31'h0000_0000, sleeping}, 32'h0000_0001);
            fire(8'h04, 1'b0, 1'b0);
            wt = 0;
            while (sleeping !== 1'b0 && wt < 20) begin
                @(posedge clk);
                wt++;
            end
            chk({31'h0000_0000, sleeping}, 32'h0000_0000);
            wait_vec(g[0]);
            wr(12'h024, 32'h0000_0004);
        end
        wr(12'h008, 32'h0000_0100);
        wr(12'h000, 32'h0000_00c1);
        fire(8'h04, 1'b0, 1'b0);
        wait_vec(1'b0);
        wr(12'h008, 32'h0000_01ff);
        wait_vec(1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc(12'h008, 32'h0000_0000);
        rdc(12'h000, 32'h0000_0001);
        complete_run();
    end
endmodule : interrupt_vectoring_unit_bench
`default_nettype wire
